// *** src/fspsc_pkg.sv ***
// constants shared by the self-program section controller
// assumes word-addressed flash of 8k words behind one system clock
// What this block does
// - program op starts only from loader section
// - loader may program any page, itself included
// - loader boundary follows loader size fuses
// - separate lock pairs for application and loader
// - fixed boundary splits concurrent and stalling regions
// - region follows target page, not fetch address
// - concurrent-region op keeps cpu running
// - stalling-region op halts cpu throughout
// - concurrent-region reads invalid while programming
// - loader section always inside stalling region
// - busy flag reads one while region blocked by a concurrent-region op
// - busy stays until software clears it
// - separate fuse selects reset vector
// - programming by pages, fetch by single words
// - fuse unprogrammed gives application reset address
// - lock bits set back to one only by chip erase or reset
// - application lock one-zero refuses application writes
package fspsc_pkg;
    localparam int ADDR_W = 13;                    // flash word address width
    localparam int DATA_W = 16;                    // flash word width
    localparam int PAGE_BITS = 6;                  // words per page, log2
    localparam int PAGE_W = ADDR_W - PAGE_BITS;    // page number width
    // fixed split: stalling region is the top 1k words
    localparam logic [ADDR_W-1:0] STALL_BASE = 13'h1c00;
    // loader start per size fuse code, largest loader starting right at the split
    localparam logic [ADDR_W-1:0] LOADER_START_3 = 13'h1f80;
    localparam logic [ADDR_W-1:0] LOADER_START_2 = 13'h1f00;
    localparam logic [ADDR_W-1:0] LOADER_START_1 = 13'h1e00;
    localparam logic [ADDR_W-1:0] LOADER_START_0 = 13'h1c00;
    localparam logic [ADDR_W-1:0] APP_RESET_ADDR = 13'h0000;
    // register port
    localparam int RA_W = 4;
    localparam int RD_W = 8;
    localparam logic [RA_W-1:0] REG_CTRL_STATUS = 4'h0;
    localparam logic [RA_W-1:0] REG_LOCK = 4'h1;
    localparam logic [RA_W-1:0] REG_FUSE = 4'h2;
    // field positions
    localparam int CS_ACTIVE_BIT = 0;
    localparam int CS_HALT_BIT = 1;
    localparam int CS_BUSY_CLR_BIT = 4;
    localparam int CS_BUSY_BIT = 6;
    localparam int LK_APP_LO = 0;
    localparam int LK_LDR_LO = 2;
    // reset values: locks unprogrammed (ones)
    localparam logic [1:0] LOCK_RESET = 2'h3;
    localparam logic [1:0] APP_LOCK_NO_WRITE = 2'h2;
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONC  = 3'b010,
        ST_STALL = 3'b100
    } fspsc_state_e;
endpackage

// *** src/fspsc_sync.sv ***
// two-flop synchroniser for static pins and slow pulses
// assumes inputs may change at any time relative to the clock
`timescale 1ns/1ps
module fspsc_sync #(
    parameter int W = 1
) (
    input  wire logic         CLK_SYS,
    input  wire logic         RESET,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;   // first stage, read by second stage only

    // both stages clear on reset
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// *** src/fspsc_region_dec.sv ***
// classifies one flash word address into section and region
// assumes loader start is already decoded from the size fuses
`timescale 1ns/1ps
module fspsc_region_dec (
    input  wire logic [fspsc_pkg::ADDR_W-1:0] addr,
    input  wire logic [fspsc_pkg::ADDR_W-1:0] loader_start,
    output logic                              in_loader,
    output logic                              in_stall
);
    // movable section split
    assign in_loader = (addr >= loader_start);
    // fixed region split, fuses play no part
    assign in_stall  = (addr >= fspsc_pkg::STALL_BASE);
endmodule

// *** src/fspsc_top.sv ***
// self-program sequencer: gates program ops, halts cpu, blocks reads
// assumes cpu request inputs and flash done come from the same clock;
// fuse and chip erase pins come from outside and are synchronised
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
module fspsc_top (
    input  wire logic                               CLK_SYS,
    input  wire logic                               RESET,
    input  wire logic [fspsc_pkg::RA_W-1:0]         REG_ADDR,
    input  wire logic [fspsc_pkg::RD_W-1:0]         REG_WDATA,
    input  wire logic                               REG_WR,
    input  wire logic                               REG_RD,
    output logic      [fspsc_pkg::RD_W-1:0]         REG_RDATA,
    input  wire logic                               PROG_REQ,
    input  wire logic [fspsc_pkg::ADDR_W-1:0]       PROG_PC,
    input  wire logic [fspsc_pkg::ADDR_W-1:0]       PROG_ADDR,
    input  wire logic                               PROG_WRITE,
    output logic                                    PROG_ACCEPT,
    output logic                                    PROG_REFUSE,
    output logic                                    CPU_HALT,
    input  wire logic                               FETCH_REQ,
    input  wire logic [fspsc_pkg::ADDR_W-1:0]       FETCH_ADDR,
    output logic                                    FETCH_VALID,
    output logic      [fspsc_pkg::DATA_W-1:0]       FETCH_DATA,
    input  wire logic [fspsc_pkg::DATA_W-1:0]       FLASH_RDATA,
    output logic                                    FLASH_START,
    output logic                                    FLASH_WRITE_OP,
    output logic      [fspsc_pkg::PAGE_W-1:0]       FLASH_PAGE,
    input  wire logic                               FLASH_DONE,
    input  wire logic [1:0]                         LOADER_SIZE_FUSES,
    input  wire logic                               RESET_VECTOR_FUSE,
    input  wire logic                               CHIP_ERASE,
    output logic      [fspsc_pkg::ADDR_W-1:0]       RESET_VECTOR
);
    localparam int AW = fspsc_pkg::ADDR_W;

    // synchronised pins
    logic [3:0]    pins_s;          // chip erase, vector fuse, size fuses
    logic [1:0]    size_fuse;       // loader size code
    logic          vec_fuse;        // reset vector select, 0 = programmed
    logic          erase_lvl;       // chip erase level after sync
    logic          erase_d_r;       // previous erase level
    logic          erase_pulse;     // rising edge of chip erase

    // decode results
    logic [AW-1:0] loader_start;    // first loader word
    logic          pc_in_loader;    // executing code sits in loader
    logic          tgt_in_loader;   // target page sits in loader
    logic          tgt_in_stall;    // target page in stalling region
    logic          fetch_in_stall;  // fetch address in stalling region
    logic          pc_in_stall;     // region of executing pc, checks only
    logic          fetch_in_loader; // section of fetch, checks only

    // state
    fspsc_pkg::fspsc_state_e state_r;
    fspsc_pkg::fspsc_state_e state_nxt;
    logic [1:0]    app_lock_r;      // application lock pair
    logic [1:0]    ldr_lock_r;      // loader lock pair
    logic          busy_r;          // concurrent region busy flag
    logic          busy_nxt;

    // request qualification
    logic          lock_ok;
    logic          accept;
    logic          refuse;
    logic          go_stall;
    logic          go_conc;
    logic          op_done;
    logic          busy_clr_wr;
    logic          lock_wr;
    logic          fetch_blocked;
    logic          fetch_ok;
    logic [fspsc_pkg::RD_W-1:0] rd_mux;

    fspsc_sync #(
        .W (4)
    ) u_pin_sync (
        .CLK_SYS (CLK_SYS),
        .RESET   (RESET),
        .d       ({CHIP_ERASE, RESET_VECTOR_FUSE, LOADER_SIZE_FUSES}),
        .q       (pins_s)
    );
    assign size_fuse = pins_s[1:0];
    assign vec_fuse  = pins_s[2];
    assign erase_lvl = pins_s[3];
    assign erase_pulse = erase_lvl && !erase_d_r;

    // loader boundary moves with the size fuses
    assign loader_start = (size_fuse == 2'h3) ? fspsc_pkg::LOADER_START_3 :
                          (size_fuse == 2'h2) ? fspsc_pkg::LOADER_START_2 :
                          (size_fuse == 2'h1) ? fspsc_pkg::LOADER_START_1 :
                                                fspsc_pkg::LOADER_START_0;

    // section of the executing instruction
    fspsc_region_dec u_pc_dec (
        .addr         (PROG_PC),
        .loader_start (loader_start),
        .in_loader    (pc_in_loader),
        .in_stall     (pc_in_stall)
    );
    // region of the page pointer, not of the fetch stream
    fspsc_region_dec u_tgt_dec (
        .addr         (PROG_ADDR),
        .loader_start (loader_start),
        .in_loader    (tgt_in_loader),
        .in_stall     (tgt_in_stall)
    );
    // region of the current fetch
    fspsc_region_dec u_fetch_dec (
        .addr         (FETCH_ADDR),
        .loader_start (loader_start),
        .in_loader    (fetch_in_loader),
        .in_stall     (fetch_in_stall)
    );

    // low lock bit programmed forbids writes into that section
    assign lock_ok = tgt_in_loader ? ldr_lock_r[0]
                                   : (app_lock_r != fspsc_pkg::APP_LOCK_NO_WRITE)
                                     && app_lock_r[0];
    // any page may be targeted, the loader itself included
    assign accept   = PROG_REQ && pc_in_loader && lock_ok
                      && (state_r == fspsc_pkg::ST_IDLE);
    assign refuse   = PROG_REQ && !accept;
    assign go_stall = accept && tgt_in_stall;
    assign go_conc  = accept && !tgt_in_stall;
    assign op_done  = FLASH_DONE && (state_r != fspsc_pkg::ST_IDLE);

    // register decode
    assign busy_clr_wr = REG_WR && (REG_ADDR == fspsc_pkg::REG_CTRL_STATUS)
                         && REG_WDATA[fspsc_pkg::CS_BUSY_CLR_BIT];
    assign lock_wr     = REG_WR && (REG_ADDR == fspsc_pkg::REG_LOCK);

    // busy: concurrent start sets, clear only when idle, set wins over clear
    assign busy_nxt = go_conc ? 1'b1 :
                      (busy_clr_wr && (state_r == fspsc_pkg::ST_IDLE)) ? 1'b0 :
                      busy_r;

    // concurrent region unreadable during any op and until cleared
    assign fetch_blocked = !fetch_in_stall
                           && (busy_r || (state_r != fspsc_pkg::ST_IDLE));
    assign fetch_ok = FETCH_REQ && !fetch_blocked && !CPU_HALT;

    assign rd_mux =
        (REG_ADDR == fspsc_pkg::REG_CTRL_STATUS) ?
            {1'b0, busy_r, 4'h0, CPU_HALT, (state_r != fspsc_pkg::ST_IDLE)} :
        (REG_ADDR == fspsc_pkg::REG_LOCK) ? {4'h0, ldr_lock_r, app_lock_r} :
        (REG_ADDR == fspsc_pkg::REG_FUSE) ? {5'h00, vec_fuse, size_fuse} :
        8'h00;

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fspsc_pkg::ST_IDLE: begin
                if (go_stall) begin
                    state_nxt = fspsc_pkg::ST_STALL;
                end else if (go_conc) begin
                    state_nxt = fspsc_pkg::ST_CONC;
                end
            end
            fspsc_pkg::ST_CONC,
            fspsc_pkg::ST_STALL: begin
                if (FLASH_DONE) begin
                    state_nxt = fspsc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = fspsc_pkg::ST_IDLE;
            end
        endcase
    end

    // state, busy flag and halt
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state_r  <= fspsc_pkg::ST_IDLE;
            busy_r   <= 1'b0;
            CPU_HALT <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            busy_r   <= busy_nxt;
            // halt held for the whole stalling op
            CPU_HALT <= go_stall || (CPU_HALT && !op_done);
        end
    end

    // lock pairs: software may only program, chip erase restores ones
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            app_lock_r <= fspsc_pkg::LOCK_RESET;
            ldr_lock_r <= fspsc_pkg::LOCK_RESET;
            erase_d_r  <= 1'b0;
        end else begin
            erase_d_r <= erase_lvl;
            if (erase_pulse) begin
                app_lock_r <= fspsc_pkg::LOCK_RESET;
                ldr_lock_r <= fspsc_pkg::LOCK_RESET;
            end else if (lock_wr) begin
                app_lock_r <= app_lock_r & REG_WDATA[fspsc_pkg::LK_APP_LO +: 2];
                ldr_lock_r <= ldr_lock_r & REG_WDATA[fspsc_pkg::LK_LDR_LO +: 2];
            end
        end
    end

    // cpu and flash side outputs
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            PROG_ACCEPT    <= 1'b0;
            PROG_REFUSE    <= 1'b0;
            FLASH_START    <= 1'b0;
            FLASH_WRITE_OP <= 1'b0;
            FLASH_PAGE     <= '0;
            FETCH_VALID    <= 1'b0;
            FETCH_DATA     <= '0;
        end else begin
            PROG_ACCEPT <= accept;
            PROG_REFUSE <= refuse;
            FLASH_START <= accept;
            if (accept) begin
                FLASH_WRITE_OP <= PROG_WRITE;
                // page number only; word bits ignored by the array
                FLASH_PAGE <= PROG_ADDR[AW-1:fspsc_pkg::PAGE_BITS];
            end
            FETCH_VALID <= fetch_ok;
            // blocked reads return zero rather than stale array data
            FETCH_DATA  <= fetch_ok ? FLASH_RDATA : '0;
        end
    end

    // register read data and reset vector
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            REG_RDATA    <= 8'h00;
            RESET_VECTOR <= fspsc_pkg::APP_RESET_ADDR;
        end else begin
            REG_RDATA    <= REG_RD ? rd_mux : 8'h00;
            RESET_VECTOR <= vec_fuse ? fspsc_pkg::APP_RESET_ADDR : loader_start;
        end
    end

    // checks
    app_refuse_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        PROG_REQ && !pc_in_loader |=> !FLASH_START && PROG_REFUSE)
        else $error("program op started from application section");
    loader_any_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        PROG_REQ && pc_in_loader && lock_ok && state_r == fspsc_pkg::ST_IDLE
        |=> FLASH_START)
        else $error("allowed loader program op not started");
    app_lock_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        PROG_REQ && !tgt_in_loader && app_lock_r == 2'h2 |=> !FLASH_START)
        else $error("locked application section written");
    stall_halt_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        state_r == fspsc_pkg::ST_STALL |-> CPU_HALT)
        else $error("cpu not halted during stalling op");
    conc_run_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        state_r == fspsc_pkg::ST_CONC |-> !CPU_HALT && busy_r)
        else $error("cpu halted or busy low during concurrent op");
    halt_release_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        state_r == fspsc_pkg::ST_STALL && FLASH_DONE |=> !CPU_HALT)
        else $error("halt not released after stalling op");
    busy_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        busy_r && !busy_clr_wr |=> busy_r)
        else $error("busy flag dropped without software clear");
    fetch_block_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        FETCH_REQ && !fetch_in_stall && busy_r |=> !FETCH_VALID)
        else $error("concurrent region read while blocked");
    loader_inside_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        loader_start >= fspsc_pkg::STALL_BASE)
        else $error("loader section outside stalling region");
    reset_vec_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !$past(RESET) |-> RESET_VECTOR == ($past(vec_fuse) ? fspsc_pkg::APP_RESET_ADDR
                                                            : $past(loader_start)))
        else $error("reset vector mismatch");
    // executing pc in loader is always in the stalling region
    pc_loader_stall_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        pc_in_loader |-> pc_in_stall)
        else $error("loader pc outside stalling region");
    // same holds for the fetch stream
    fetch_loader_stall_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        fetch_in_loader |-> fetch_in_stall)
        else $error("loader fetch outside stalling region");
    // concurrent op raises busy and leaves the cpu running
    conc_busy_set_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        go_conc |=> busy_r && !CPU_HALT)
        else $error("busy not set by concurrent op");
    // stalling op halts from its first cycle
    stall_start_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        go_stall |=> CPU_HALT && state_r == fspsc_pkg::ST_STALL)
        else $error("cpu not halted at stalling op start");
    // halted cpu gets no fetch data
    halt_fetch_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        CPU_HALT |=> !FETCH_VALID)
        else $error("fetch served while cpu halted");
    // page handed to the array is the pointer's page
    page_latch_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        accept |=> FLASH_START && FLASH_PAGE == $past(PROG_ADDR[AW-1:fspsc_pkg::PAGE_BITS]))
        else $error("wrong page handed to flash");
    // status read shows busy and halt as they stood
    status_bits_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        REG_RD && REG_ADDR == fspsc_pkg::REG_CTRL_STATUS
        |=> REG_RDATA[fspsc_pkg::CS_BUSY_BIT] == $past(busy_r)
            && REG_RDATA[fspsc_pkg::CS_HALT_BIT] == $past(CPU_HALT))
        else $error("status read shows wrong busy or halt");
    // chip erase restores both lock pairs
    erase_unlock_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        erase_pulse |=> app_lock_r == fspsc_pkg::LOCK_RESET
                        && ldr_lock_r == fspsc_pkg::LOCK_RESET)
        else $error("lock bits not restored by chip erase");
    // without chip erase no lock bit goes back to one
    lock_one_way_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !erase_pulse |=> (app_lock_r & ~$past(app_lock_r)) == 2'h0
                         && (ldr_lock_r & ~$past(ldr_lock_r)) == 2'h0)
        else $error("lock bit set to one without chip erase");
endmodule

// *** tb/fspsc_flash_model.sv ***
// behavioural flash array facing the sequencer
// assumes one clock; op length is set live by the bench
`timescale 1ns/1ps
module fspsc_flash_model (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        flash_start,
    input  wire logic [12:0] fetch_addr,
    input  wire logic [3:0]  dly,
    output logic      [15:0] flash_rdata,
    output logic             flash_done
);
    int cnt;                                // cycles left in the running op
    // address-tagged word, so a stale or shifted read shows up
    assign flash_rdata = {3'h5, fetch_addr};
    // one done pulse per start, never early, never repeated
    always @(posedge clk_sys) begin
        if (reset) begin
            cnt <= 0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (cnt == 1);
            if (flash_start) begin
                cnt <= dly + 1;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// *** tb/test_flash_self_program_section_ctrl.sv ***
// self-checking bench for the self-program sequencer
// assumes the flash model answers ops; fuses are set as reset is raised
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_flash_self_program_section_ctrl;
    logic        clk_sys = 0, reset = 1, we = 0, re = 0, req = 0, pwr = 0, freq = 0, ce = 0;
    logic [3:0]  ra = 0, dly = 4'h6;
    logic [7:0]  wd = 0, rdat;
    logic [12:0] ppc = 0, paddr = 0, faddr = 0, rvec;
    logic [1:0]  szf = 0;
    logic        vecf = 0, acc, refd, halt, fval, fst, fwop, done;
    logic [15:0] fdat, frd;
    logic [6:0]  fpage;
    int mismatches = 0, comparisons = 0, seed = 83371;
    int ls, app, ldr, busy, active, stall;   // reference model state
    int starts [4] = '{'h1c00, 'h1e00, 'h1f00, 'h1f80};
    always #2.5 clk_sys = ~clk_sys;
    fspsc_top u_dut (.CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(ra), .REG_WDATA(wd),
        .REG_WR(we), .REG_RD(re), .REG_RDATA(rdat), .PROG_REQ(req), .PROG_PC(ppc),
        .PROG_ADDR(paddr), .PROG_WRITE(pwr), .PROG_ACCEPT(acc), .PROG_REFUSE(refd),
        .CPU_HALT(halt), .FETCH_REQ(freq), .FETCH_ADDR(faddr), .FETCH_VALID(fval),
        .FETCH_DATA(fdat), .FLASH_RDATA(frd), .FLASH_START(fst), .FLASH_WRITE_OP(fwop),
        .FLASH_PAGE(fpage), .FLASH_DONE(done), .LOADER_SIZE_FUSES(szf),
        .RESET_VECTOR_FUSE(vecf), .CHIP_ERASE(ce), .RESET_VECTOR(rvec));
    fspsc_flash_model u_flash (.clk_sys(clk_sys), .reset(reset), .flash_start(fst),
        .fetch_addr(faddr), .dly(dly), .flash_rdata(frd), .flash_done(done));
    // random word addresses inside each fixed region
    function automatic int conc_addr();
        return $unsigned($random(seed)) % 'h1c00;
    endfunction
    function automatic int stall_addr();
        return 'h1c00 + $unsigned($random(seed)) % 'h400;
    endfunction
    // fuses set with reset, reset held 3 cycles, then wait for synced fuses
    task automatic do_reset(input int sz);
        @(posedge clk_sys);
        szf <= sz;
        vecf <= (sz == 3);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        ls = starts[sz]; app = 3; ldr = 3; busy = 0; active = 0; stall = 0;
    endtask
    // one-cycle write strobe, model follows
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        we <= 1'b1; ra <= a; wd <= d;
        @(posedge clk_sys);
        we <= 1'b0;
        if (a == 4'h1) begin
            app = app & d[1:0]; ldr = ldr & d[3:2];
        end
        if (a == 4'h0 && d[4] && !active) busy = 0;
    endtask
    // one-cycle read strobe, data looked at in the following cycle only
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
        @(posedge clk_sys);
        re <= 1'b1; ra <= a;
        @(posedge clk_sys);
        re <= 1'b0;
        #1;
        `CHK(n, e, rdat);
    endtask
    // program request; accept decision from the reference model
    task automatic prog_start(input int pc, input int tgt, input logic w);
        logic e;
        e = !active && pc >= ls && ((tgt >= ls) ? ldr[0] : app[0]);
        @(posedge clk_sys);
        req <= 1'b1; ppc <= pc; paddr <= tgt; pwr <= w;
        @(posedge clk_sys);
        req <= 1'b0;
        #1;
        `CHK("accept", e, acc);
        `CHK("refuse", !e, refd);
        `CHK("start", e, fst);
        if (e) begin
            active = 1; stall = (tgt >= 'h1c00);
            if (!stall) busy = 1;
            `CHK("page", tgt >> 6, fpage);
            `CHK("wop", w, fwop);
            `CHK("halt", stall, halt);
        end
    endtask
    // wait for the array, then the halt must drop one edge later
    task automatic prog_end();
        repeat (40) begin
            if (done === 1'b1) break;
            @(posedge clk_sys);
            #1;
        end
        `CHK("done", 1'b1, done);
        @(posedge clk_sys);
        #1;
        `CHK("halt_end", 1'b0, halt);
        active = 0; stall = 0;
    endtask
    // fetch; blocked by halt, or low region while busy or active
    task automatic fetch(input int a);
        logic v;
        v = !(active && stall) && !(a < 'h1c00 && (busy || active));
        @(posedge clk_sys);
        freq <= 1'b1; faddr <= a;
        @(posedge clk_sys);
        freq <= 1'b0;
        #1;
        `CHK("fvalid", v, fval);
        `CHK("fdata", (v ? {3'h5, a[12:0]} : 16'h0), fdat);
    endtask
    task automatic wrap_up();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // cut a hang short well beyond the expected run
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
    initial begin
        // every loader size: vector, boundary, self-rewrite under halt
        for (int sz = 0; sz < 4; sz++) begin
            do_reset(sz);
            `CHK("vector", (sz == 3) ? 0 : starts[sz], rvec);
            rd(4'h2, {5'h0, sz == 3, sz[1:0]}, "fuse");
            prog_start(ls - 1, stall_addr(), 1'b0);
            dly <= 4'h6 + ($unsigned($random(seed)) % 8);
            prog_start(ls, ls, 1'b1);
            fetch(ls);
            prog_end();
        end
        $display("test sizes done");
        rd(4'h0, 8'h00, "status");
        rd(4'h1, 8'h0f, "lock");
        rd(4'h5, 8'h00, "unmapped");
        $display("test registers done");
        // concurrent op: cpu runs, low region blocked until cleared
        dly <= 4'hf;
        prog_start(ls, conc_addr(), 1'b0);
        fetch(stall_addr());
        fetch(conc_addr());
        rd(4'h0, 8'h41, "status_busy");
        wr(4'h0, 8'h10);
        prog_end();
        rd(4'h0, 8'h40, "status_kept");
        fetch(conc_addr());
        wr(4'h0, 8'h10);
        rd(4'h0, 8'h00, "status_clr");
        fetch(conc_addr());
        $display("test concurrent done");
        // lock pairs, one-way clearing and chip erase
        dly <= 4'h3;
        wr(4'h1, 8'h0e);
        rd(4'h1, 8'h0e, "lock_app");
        prog_start(ls, conc_addr(), 1'b1);
        prog_start(ls, ls, 1'b0);
        prog_end();
        wr(4'h1, 8'h0b);
        rd(4'h1, 8'h0a, "lock_and");
        prog_start(ls, ls, 1'b1);
        @(posedge clk_sys);
        ce <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ce <= 1'b0;
        repeat (4) @(posedge clk_sys);
        app = 3; ldr = 3;
        rd(4'h1, 8'h0f, "lock_erase");
        prog_start(ls, conc_addr(), 1'b1);
        prog_end();
        $display("test locks done");
        wrap_up();
    end
endmodule
